// ---- core/dacseq_pkg.sv ----
package dacseq_pkg;

  // Clock and settle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_TIME_NS = 6000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths
  localparam int BUS_W = 16;
  localparam int DAC_W = 12;

  // Subaddress values
  localparam logic [1:0] SUB_DATA = 2'h0;
  localparam logic [1:0] SUB_CTRL = 2'h1;
  localparam logic [1:0] SUB_READ = 2'h3;

  // Write codes at the data subaddress
  localparam logic [2:0] CODE_LOAD_ONLY = 3'h0;
  localparam logic [2:0] CODE_WR_IMMEDIATE = 3'h1;
  localparam logic [2:0] CODE_WR_IN_TURN = 3'h2;
  localparam logic [2:0] CODE_WR_BULK = 3'h3;
  localparam logic [2:0] CODE_WR_THEN_WAIT = 3'h4;
  localparam logic [2:0] CODE_LOAD_AND_GROUP = 3'h5;

  // Control codes at the control subaddress
  localparam logic [2:0] CODE_FIRE_UPDATE = 3'h0;
  localparam logic [2:0] CODE_ARM = 3'h1;
  localparam logic [2:0] CODE_OUTPUT_KILL = 3'h2;
  localparam logic [2:0] CODE_OUTPUT_RESTORE = 3'h3;
  localparam logic [2:0] CODE_CLEAR_FLAGS = 3'h4;

  // Read codes at the read subaddress
  localparam logic [2:0] CODE_HELD_VALUE_QUERY = 3'h0;
  localparam logic [2:0] CODE_STATE_QUERY = 3'h1;

  // Status word field positions
  localparam int ST_SETTLE_BIT = 0;
  localparam int ST_CONVERTING_BIT = 1;
  localparam int ST_ARMED_BIT = 2;
  localparam int ST_TYPE_LSB = 3;
  localparam int ST_SIZE_BIT = 6;
  localparam int ST_ID_LSB = 7;
  localparam int ST_STEP_LSB = 13;

  // Identity fields, values arbitrary
  localparam logic [2:0] ID_STEP_CODE = 3'h5;
  localparam logic [5:0] ID_CARD_CODE = 6'h15;
  localparam logic ID_SIZE_CODE = 1'b0;
  localparam logic [2:0] ID_TYPE_CODE = 3'h0;

  // Reset values
  localparam logic [15:0] HOLD_RESET = 16'h0000;
  localparam logic [11:0] RANK2_RESET = 12'h000;

  // Latched backplane control lines
  typedef struct packed {
    logic slot_select;
    logic read;
    logic [1:0] sub_select;
    logic [2:0] code;
  } dacseq_cmd_s;

endpackage : dacseq_pkg

// ---- core/dacseq_settle_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module dacseq_settle_timer #(
  parameter int COUNT = dacseq_pkg::SETTLE_CYCLES
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  output logic done_out
);
  import dacseq_pkg::*;

  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] count;
  logic running;
  logic [CW-1:0] next_count;
  logic next_running;
  logic next_done;

  // Restart on every start, pulse once at the end of the interval
  always_comb begin
    next_count = count;
    next_running = running;
    next_done = 1'b0;
    if (start_in) begin
      next_count = '0;
      next_running = 1'b1;
    end else if (running) begin
      if (count == LAST) begin
        next_running = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count + CW'(1);
      end
    end
  end

  // Timer state
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count <= '0;
      running <= 1'b0;
      done_out <= 1'b0;
    end else begin
      count <= next_count;
      running <= next_running;
      done_out <= next_done;
    end
  end

endmodule : dacseq_settle_timer
`default_nettype wire

// ---- core/dacseq_trig_edge.sv ----
`timescale 1ns/10ps
`default_nettype none
module dacseq_trig_edge (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic trig_in,
  input wire logic rising_sel_in,
  output logic fire_out
);
  import dacseq_pkg::*;

  logic trig_d;
  logic next_fire;

  // Pick the edge chosen by the polarity select
  always_comb begin
    next_fire = rising_sel_in ? (trig_in & ~trig_d) : (~trig_in & trig_d);
  end

  // Previous trigger level and the edge pulse
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      trig_d <= 1'b0;
      fire_out <= 1'b0;
    end else begin
      trig_d <= trig_in;
      fire_out <= next_fire;
    end
  end

endmodule : dacseq_trig_edge
`default_nettype wire

// ---- core/dacseq_top.sv ----
// How it works
// - Each output-type write to the card captures a 16-bit word into holding.
// - Held-value query returns holding contents anytime without changing it.
// - Load-only stops after loading; other output writes start a cycle.
// - A cycle copies low twelve bits of the chosen source into rank two.
// - Rank-two MSB is inverted toward the converter.
// - Each cycle raises the converting flag, driven out.
// - Each cycle starts a 6 us settle timer; expiry raises settle done.
// - After load-only, fire-update or selected trigger edge starts a cycle.
// - Completion request whenever settle done and armed are both high, in either order.
// - Immediate, in-turn, bulk, then-wait arm on load; others need arm command.
// - Clear-flags code clears armed, settle done and group flag only.
// - Load-and-group, then-wait and immediate set the group flag.
// - Output-restore reenables output only while remote allow is high.
// - Power-up clear resets control and holding; nothing else clears holding.
// - Gate-on low until first rank-two load, high until output-kill or reset.
// - Converter inputs zero while gate-on or remote allow low.
// - Control lines latched on each line-latch pulse, then decoded.
// - Data lines feed holding on writes, return buffers drive on reads.
// - Subaddress 0 with a write code makes the hold load pulse.
// - Word choose low selects external data, high selects holding bits.
// - Rank two loads only in a cycle, pulse right after hold load.
// - Timer expiry sets settle done and clears converting together.
// - State query returns armed, converting, settle done in low bits.
// - Arming load clears settle done and sets armed at once.
`timescale 1ns/10ps
`default_nettype none
module dacseq_top (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire dacseq_pkg::dacseq_cmd_s ctrl_lines_in,
  input wire logic line_latch_pulse_in,
  input wire logic [dacseq_pkg::BUS_W-1:0] data_in,
  input wire logic [dacseq_pkg::DAC_W-1:0] ext_data_in,
  input wire logic remote_word_choose_in,
  input wire logic remote_output_allow_in,
  input wire logic ext_trigger_in,
  input wire logic trig_rising_sel_in,
  output logic [dacseq_pkg::BUS_W-1:0] data_out,
  output logic data_oe_out,
  output logic bus_direction_read_out,
  output logic [dacseq_pkg::DAC_W-1:0] dac_code_out,
  output logic converting_flag_out,
  output logic settle_done_out,
  output logic armed_out,
  output logic completion_req_out,
  output logic output_gate_on_out
);
  import dacseq_pkg::*;

  // Expiry window for the settle check, counted after the eight quiet cycles
  localparam int SETTLE_LO = SETTLE_CYCLES - 8;
  localparam int SETTLE_HI = SETTLE_CYCLES;

  dacseq_cmd_s cmd;
  logic cmd_valid;
  logic hold_reg_load_pulse;
  logic auto_pend;
  logic rank2_load_pulse;
  logic [BUS_W-1:0] holding_word;
  logic [DAC_W-1:0] rank2_word;
  logic converting_flag;
  logic settle_done;
  logic armed;
  logic group_flag;
  logic output_gate_on;
  logic ever_loaded;
  logic read_active;
  logic read_status;
  logic timer_done;
  logic trig_fire;

  dacseq_cmd_s next_cmd;
  logic next_cmd_valid;
  logic next_hold_pulse;
  logic next_auto_pend;
  logic next_rank2_pulse;
  logic [BUS_W-1:0] next_holding_word;
  logic [DAC_W-1:0] next_rank2_word;
  logic next_converting;
  logic next_settle;
  logic next_armed;
  logic next_group;
  logic next_gate_on;
  logic next_ever_loaded;
  logic next_read_active;
  logic next_read_status;
  logic [BUS_W-1:0] next_data_out;
  logic [DAC_W-1:0] next_dac_code;
  logic [BUS_W-1:0] status_word;
  logic wr_data;
  logic wr_ctrl;
  logic is_load;
  logic is_arming;
  logic is_grouping;
  logic do_fire;
  logic do_arm;
  logic do_kill;
  logic do_restore;
  logic do_clear;

  // Decoded commands, valid for one cycle after each latch
  always_comb begin
    wr_data = cmd_valid & cmd.slot_select & ~cmd.read & (cmd.sub_select == SUB_DATA);
    wr_ctrl = cmd_valid & cmd.slot_select & ~cmd.read & (cmd.sub_select == SUB_CTRL);
    is_load = wr_data & (cmd.code <= CODE_LOAD_AND_GROUP);
    is_arming = is_load & ((cmd.code == CODE_WR_IMMEDIATE) | (cmd.code == CODE_WR_IN_TURN)
      | (cmd.code == CODE_WR_BULK) | (cmd.code == CODE_WR_THEN_WAIT));
    is_grouping = is_load & ((cmd.code == CODE_LOAD_AND_GROUP)
      | (cmd.code == CODE_WR_THEN_WAIT) | (cmd.code == CODE_WR_IMMEDIATE));
    do_fire = wr_ctrl & (cmd.code == CODE_FIRE_UPDATE);
    do_arm = wr_ctrl & (cmd.code == CODE_ARM);
    do_kill = wr_ctrl & (cmd.code == CODE_OUTPUT_KILL);
    do_restore = wr_ctrl & (cmd.code == CODE_OUTPUT_RESTORE);
    do_clear = wr_ctrl & (cmd.code == CODE_CLEAR_FLAGS);
  end

  // Status word for the state query
  always_comb begin
    status_word = '0;
    status_word[ST_SETTLE_BIT] = settle_done;
    status_word[ST_CONVERTING_BIT] = converting_flag;
    status_word[ST_ARMED_BIT] = armed;
    status_word[ST_TYPE_LSB +: 3] = ID_TYPE_CODE;
    status_word[ST_SIZE_BIT] = ID_SIZE_CODE;
    status_word[ST_ID_LSB +: 6] = ID_CARD_CODE;
    status_word[ST_STEP_LSB +: 3] = ID_STEP_CODE;
  end

  // Line latch and the load pulses
  always_comb begin
    next_cmd = line_latch_pulse_in ? ctrl_lines_in : cmd;
    next_cmd_valid = line_latch_pulse_in;
    next_hold_pulse = is_load;
    next_auto_pend = is_load & (cmd.code != CODE_LOAD_ONLY);
    next_rank2_pulse = (hold_reg_load_pulse & auto_pend) | do_fire | trig_fire;
    next_holding_word = next_hold_pulse ? data_in : holding_word;
    next_rank2_word = rank2_word;
    if (next_rank2_pulse) begin
      next_rank2_word = remote_word_choose_in ? holding_word[DAC_W-1:0]
        : ext_data_in;
    end
  end

  // Sequencer flags; every hardware set wins over a clear in the same cycle, except output-kill beats any gate-on set
  always_comb begin
    next_converting = converting_flag;
    next_settle = settle_done;
    next_armed = armed;
    next_group = group_flag;
    next_gate_on = output_gate_on;
    next_ever_loaded = ever_loaded | rank2_load_pulse;
    if (do_clear) begin
      next_armed = 1'b0;
      next_settle = 1'b0;
      next_group = 1'b0;
    end
    if (is_arming) begin
      next_settle = 1'b0;
      next_armed = 1'b1;
    end
    if (do_arm) begin
      next_armed = 1'b1;
    end
    if (is_grouping) begin
      next_group = 1'b1;
    end
    if (timer_done) begin
      next_settle = 1'b1;
      next_converting = 1'b0;
    end
    if (rank2_load_pulse) begin
      next_converting = 1'b1;
    end
    if (do_kill) begin
      next_gate_on = 1'b0;
    end else if (rank2_load_pulse) begin
      next_gate_on = 1'b1;
    end else if (do_restore & remote_output_allow_in & ever_loaded) begin
      next_gate_on = 1'b1;
    end
  end

  // Read path and converter drive
  always_comb begin
    next_read_active = read_active;
    next_read_status = read_status;
    if (line_latch_pulse_in) begin
      next_read_active = 1'b0;
    end else if (cmd_valid) begin
      next_read_active = cmd.slot_select & cmd.read & (cmd.sub_select == SUB_READ);
      next_read_status = cmd.code == CODE_STATE_QUERY;
    end
    next_data_out = '0;
    if (next_read_active) begin
      next_data_out = next_read_status ? status_word : holding_word;
    end
    next_dac_code = '0;
    if (output_gate_on & remote_output_allow_in) begin
      next_dac_code = {~rank2_word[DAC_W-1], rank2_word[DAC_W-2:0]};
    end
  end

  // State registers; power-up clear is the only reset
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd <= '0;
      cmd_valid <= 1'b0;
      hold_reg_load_pulse <= 1'b0;
      auto_pend <= 1'b0;
      rank2_load_pulse <= 1'b0;
      holding_word <= HOLD_RESET;
      rank2_word <= RANK2_RESET;
      converting_flag <= 1'b0;
      settle_done <= 1'b0;
      armed <= 1'b0;
      group_flag <= 1'b0;
      output_gate_on <= 1'b0;
      ever_loaded <= 1'b0;
      read_active <= 1'b0;
      read_status <= 1'b0;
      data_out <= '0;
      dac_code_out <= '0;
      completion_req_out <= 1'b0;
    end else begin
      cmd <= next_cmd;
      cmd_valid <= next_cmd_valid;
      hold_reg_load_pulse <= next_hold_pulse;
      auto_pend <= next_auto_pend;
      rank2_load_pulse <= next_rank2_pulse;
      holding_word <= next_holding_word;
      rank2_word <= next_rank2_word;
      converting_flag <= next_converting;
      settle_done <= next_settle;
      armed <= next_armed;
      group_flag <= next_group;
      output_gate_on <= next_gate_on;
      ever_loaded <= next_ever_loaded;
      read_active <= next_read_active;
      read_status <= next_read_status;
      data_out <= next_data_out;
      dac_code_out <= next_dac_code;
      completion_req_out <= next_settle & next_armed;
    end
  end

  // Pin copies of internal flags
  assign data_oe_out = read_active;
  assign bus_direction_read_out = read_active;
  assign converting_flag_out = converting_flag;
  assign settle_done_out = settle_done;
  assign armed_out = armed;
  assign output_gate_on_out = output_gate_on;

  // Settle timer, started by each rank-two load
  dacseq_settle_timer #(
    .COUNT(SETTLE_CYCLES)
  ) u_timer (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .start_in(rank2_load_pulse),
    .done_out(timer_done)
  );

  // External trigger edge
  dacseq_trig_edge u_trig (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .trig_in(ext_trigger_in),
    .rising_sel_in(trig_rising_sel_in),
    .fire_out(trig_fire)
  );

  // Checks
  sequence s_auto_load;
    hold_reg_load_pulse && auto_pend;
  endsequence

  sequence s_cycle_start;
    rank2_load_pulse ##1 converting_flag;
  endsequence

  AST_AUTO_CYCLE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    s_auto_load |=> s_cycle_start) else $error("auto cycle did not start");
  AST_LOAD_ONLY: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (hold_reg_load_pulse && !auto_pend && !do_fire && !trig_fire) |=> !rank2_load_pulse)
    else $error("load only started a cycle");
  AST_HOLD_STABLE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !hold_reg_load_pulse |-> holding_word == $past(holding_word))
    else $error("holding changed without load");
  AST_SETTLE_TIME: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (rank2_load_pulse && !$past(rank2_load_pulse)) ##1 (!rank2_load_pulse)[*8]
    |-> ##[SETTLE_LO:SETTLE_HI] timer_done)
    else $error("settle time wrong");
  AST_DONE_FLAGS: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (timer_done && !rank2_load_pulse) |=> settle_done && !converting_flag)
    else $error("expiry flags wrong");
  AST_IRQ_ARMED: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    completion_req_out |-> settle_done && armed)
    else $error("completion without arm");
  AST_CLEAR: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (do_clear && !timer_done && !is_arming && !do_arm) |=> !armed && !settle_done && !group_flag)
    else $error("clear code failed");
  AST_ARM_LOAD: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (is_arming && !timer_done) |=> armed && !settle_done && hold_reg_load_pulse)
    else $error("arming load wrong");
  AST_FORCE_ZERO: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !(output_gate_on && remote_output_allow_in) |=> dac_code_out == '0)
    else $error("converter not forced to zero");
  AST_MSB_INV: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (output_gate_on && remote_output_allow_in) |=>
    dac_code_out == {~$past(rank2_word[DAC_W-1]), $past(rank2_word[DAC_W-2:0])})
    else $error("converter code wrong");
  AST_GATE_FIRST: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !ever_loaded |-> !output_gate_on) else $error("gate on before first load");
  AST_GROUP_SET: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    is_grouping |=> group_flag) else $error("grouping load left group flag low");
  AST_GROUP_KEEP: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (is_load && !is_grouping && !group_flag) |=> !group_flag)
    else $error("plain load set group flag");

endmodule : dacseq_top
`default_nettype wire

// ---- verif/dacseq_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module dacseq_host_model (
  input wire logic mclk_in,
  input wire logic [dacseq_pkg::BUS_W-1:0] rd_data_in,
  output dacseq_pkg::dacseq_cmd_s ctrl_lines_out,
  output logic line_latch_pulse_out,
  output logic [dacseq_pkg::BUS_W-1:0] data_out
);
  import dacseq_pkg::*;

  // Idle backplane at time zero
  initial begin
    ctrl_lines_out = '0;
    line_latch_pulse_out = 1'b0;
    data_out = 16'h0000;
  end

  // One access: latch edge, data edge, then answer sampled after the fourth edge
  task automatic access(input logic sel, input logic rd, input logic [1:0] sub,
                        input logic [2:0] code, input logic [BUS_W-1:0] wdata,
                        output logic [BUS_W-1:0] rdata);
    @(posedge mclk_in);
    #1;
    ctrl_lines_out = '{sel, rd, sub, code};
    line_latch_pulse_out = 1'b1;
    data_out = wdata;
    @(posedge mclk_in);
    #1;
    line_latch_pulse_out = 1'b0;
    @(posedge mclk_in);
    #1;
    data_out = ~wdata; // Released bus shows no stale word
    @(posedge mclk_in);
    #1;
    rdata = rd_data_in;
  endtask : access
endmodule : dacseq_host_model
`default_nettype wire

// ---- verif/test_dac_card_output_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_dac_card_output_sequencer;
  import dacseq_pkg::*;
  logic mclk_in, sys_rst_in, word_sel, allow, trig, trig_sel, latch;
  logic oe, dir, conv, settle, armed, req, gate;
  dacseq_cmd_s ctrl;
  logic [BUS_W-1:0] bus_wr, rd_data, r, e;
  logic [DAC_W-1:0] ext_data, dac;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Host on the backplane and the card
  dacseq_host_model host (.mclk_in(mclk_in), .rd_data_in(rd_data), .ctrl_lines_out(ctrl),
    .line_latch_pulse_out(latch), .data_out(bus_wr));
  dacseq_top dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ctrl_lines_in(ctrl),
    .line_latch_pulse_in(latch), .data_in(bus_wr), .ext_data_in(ext_data),
    .remote_word_choose_in(word_sel), .remote_output_allow_in(allow),
    .ext_trigger_in(trig), .trig_rising_sel_in(trig_sel), .data_out(rd_data),
    .data_oe_out(oe), .bus_direction_read_out(dir), .dac_code_out(dac),
    .converting_flag_out(conv), .settle_done_out(settle), .armed_out(armed),
    .completion_req_out(req), .output_gate_on_out(gate));

  // Clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // Hang guard
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      $display("ERROR at %0t: timeout", $time);
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] s, input logic [15:0] x);
    samples_checked++;
    if (s !== x) begin
      error_cnt++;
      $display("ERROR at %0t: saw %h expected %h", $time, s, x);
    end
  endtask : check

  task automatic w(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : w

  // Wait out a whole settle interval
  task automatic ws();
    w(SETTLE_CYCLES + 20);
  endtask : ws

  task automatic wr(input logic [1:0] sub, input logic [2:0] code, input logic [15:0] d);
    host.access(1'b1, 1'b0, sub, code, d, r);
  endtask : wr

  task automatic rq(input logic [2:0] code);
    host.access(1'b1, 1'b1, SUB_READ, code, 16'h0000, r);
  endtask : rq

  // Flags in order converting, settle, armed, request, gate
  task automatic fl(input logic [4:0] x);
    check({11'h000, conv, settle, armed, req, gate}, {11'h000, x});
  endtask : fl

  task automatic gd(input logic g, input logic [11:0] d);
    check({3'b000, gate, dac}, {3'b000, g, d});
  endtask : gd

  function automatic logic [15:0] stw(input logic a, input logic c, input logic s);
    return {ID_STEP_CODE, ID_CARD_CODE, ID_SIZE_CODE, ID_TYPE_CODE, a, c, s};
  endfunction : stw

  // Main sequence
  initial begin
    sys_rst_in = 1'b1;
    ext_data = 12'h000;
    word_sel = 1'b1;
    allow = 1'b1;
    trig = 1'b0;
    trig_sel = 1'b1;
    w(20);
    sys_rst_in = 1'b0;
    fl(5'b00000);
    $display("test reset done");
    wr(SUB_DATA, CODE_LOAD_ONLY, 16'ha5c3);
    w(4);
    fl(5'b00000);
    gd(1'b0, 12'h000);
    rq(CODE_HELD_VALUE_QUERY);
    check(r, 16'ha5c3);
    check({14'h0000, oe, dir}, 16'h0003);
    $display("test load only done");
    wr(SUB_CTRL, CODE_FIRE_UPDATE, 16'h0000);
    w(4);
    fl(5'b10001);
    check({14'h0000, oe, dir}, 16'h0000);
    gd(1'b1, 12'hdc3);
    rq(CODE_HELD_VALUE_QUERY);
    check(r, 16'ha5c3);
    ws();
    fl(5'b01001);
    $display("test fire done");
    wr(SUB_CTRL, CODE_ARM, 16'h0000);
    w(3);
    fl(5'b01111);
    wr(SUB_CTRL, CODE_CLEAR_FLAGS, 16'h0000);
    w(3);
    fl(5'b00001);
    gd(1'b1, 12'hdc3);
    $display("test arm done");
    for (int c = 1; c <= 5; c++) begin
      wr(SUB_DATA, 3'(c), {4'h0, 4'(c), 8'h21});
      w(4);
      rq(CODE_STATE_QUERY);
      e = stw(c <= 4, 1'b1, 1'b0);
      check({r[15:1], 1'b0}, {e[15:1], 1'b0});
      if (c <= 4) check({15'h0000, r[0]}, 16'h0000);
      check({4'h0, dac}, {4'h0, 4'(c) ^ 4'h8, 8'h21});
      ws();
      check({15'h0000, req}, {15'h0000, c <= 4});
      wr(SUB_CTRL, CODE_CLEAR_FLAGS, 16'h0000);
      wr(SUB_CTRL, CODE_FIRE_UPDATE, 16'h0000);
      ws();
    end
    $display("test write codes done");
    wr(SUB_CTRL, CODE_OUTPUT_KILL, 16'h0000);
    w(3);
    gd(1'b0, 12'h000);
    allow = 1'b0;
    wr(SUB_CTRL, CODE_OUTPUT_RESTORE, 16'h0000);
    w(3);
    gd(1'b0, 12'h000);
    allow = 1'b1;
    w(3);
    gd(1'b0, 12'h000);
    wr(SUB_CTRL, CODE_OUTPUT_RESTORE, 16'h0000);
    w(3);
    gd(1'b1, 12'hd21);
    allow = 1'b0;
    w(3);
    gd(1'b1, 12'h000);
    allow = 1'b1;
    w(3);
    gd(1'b1, 12'hd21);
    $display("test disable done");
    word_sel = 1'b0;
    ext_data = 12'h7ff;
    wr(SUB_CTRL, CODE_FIRE_UPDATE, 16'h0000);
    w(4);
    gd(1'b1, 12'hfff);
    ws();
    ext_data = 12'h123;
    trig = 1'b1;
    w(5);
    fl(5'b11001);
    gd(1'b1, 12'h923);
    ws();
    trig_sel = 1'b0;
    ext_data = 12'h456;
    w(2);
    trig = 1'b0;
    w(5);
    gd(1'b1, 12'hc56);
    ws();
    ext_data = 12'h789;
    trig = 1'b1;
    w(5);
    fl(5'b01001);
    gd(1'b1, 12'hc56);
    $display("test trigger done");
    word_sel = 1'b1;
    host.access(1'b0, 1'b0, SUB_DATA, CODE_LOAD_ONLY, 16'hffff, r);
    rq(CODE_HELD_VALUE_QUERY);
    check(r, 16'h0521);
    sys_rst_in = 1'b1;
    w(2);
    sys_rst_in = 1'b0;
    w(2);
    rq(CODE_HELD_VALUE_QUERY);
    check(r, 16'h0000);
    fl(5'b00000);
    $display("test refusal and reset done");
    conclude();
  end
endmodule : test_dac_card_output_sequencer
`default_nettype wire
